// *** core/pwm_channel.sv ***
`timescale 1ns/10ps
module pwm_channel
	import pwm_ctrl_pkg::*;
(
	input wire logic i_ref_clk,
	input wire logic i_rst_n,
	input wire logic i_tick,
	input wire logic i_div2,
	input wire logic i_run,
	input wire logic i_on,
	input wire logic [7:0] i_duty,
	input wire logic [2:0] i_delay,
	input wire logic i_force,
	input wire logic i_kill,
	output logic o_out
);
	logic pre_r, pre_nxt;
	logic [7:0] dly_r, dly_nxt;
	logic [7:0] cnt_r, cnt_nxt;
	logic out_nxt;
	logic adv;
	logic dly_done;
	logic [7:0] dly_target;

	assign dly_target = {i_delay, {DLY_UNIT_W{1'b0}}}; // [RULE5]
	assign dly_done = (dly_r == dly_target);

	always_comb
	begin
		pre_nxt = pre_r;
		dly_nxt = dly_r;
		cnt_nxt = cnt_r;
		adv = 1'b0;
		if (!i_run)
		begin
			pre_nxt = 1'b0;
			dly_nxt = 8'h00;
			cnt_nxt = 8'h00;
		end
		else if (i_tick)
		begin
			pre_nxt = i_div2 ? ~pre_r : 1'b0; // [RULE4]
			adv = !i_div2 || pre_r; // [RULE3]
			if (adv && !dly_done)
				dly_nxt = dly_r + 8'h01; // [RULE5]
			else if (adv)
				cnt_nxt = cnt_r + 8'h01; // [RULE24]
		end
		if (i_kill || !i_on)
			out_nxt = 1'b0; // [RULE2]
		else if (i_force || !i_run)
			out_nxt = 1'b1; // [RULE9]
		else if (!dly_done)
			out_nxt = 1'b0;
		else if (i_duty == DUTY_FULL)
			out_nxt = 1'b1;
		else
			out_nxt = (cnt_r <= i_duty); // [RULE2] [RULE24]
	end

	// counters restart together on the run edge, so two channels fed one tick stay aligned
	always_ff @(posedge i_ref_clk)
	begin
		if (!i_rst_n)
		begin
			pre_r <= 1'b0;
			dly_r <= 8'h00;
			cnt_r <= 8'h00;
			o_out <= 1'b0;
		end
		else
		begin
			pre_r <= pre_nxt;
			dly_r <= dly_nxt;
			cnt_r <= cnt_nxt; // [RULE7]
			o_out <= out_nxt;
		end
	end

	a_off_when_low: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // [RULE2]
		!i_on |=> !o_out) else $error("output on while channel-on is low");
	a_full_on_code: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // [RULE2]
		(i_on && i_run && !i_kill && dly_done && i_duty == DUTY_FULL) |=> o_out)
		else $error("full duty code not fully on");
	a_force_follow: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // [RULE9]
		(i_force && !i_kill) |=> (o_out == $past(i_on))) else $error("clock fail not following on bit");
	a_delay_hold: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // [RULE5]
		(i_run && !dly_done && !i_force) |=> !o_out) else $error("output during switch-on delay");
	a_delay_bound: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // [RULE5]
		dly_r <= dly_target || !i_run) else $error("delay counter overran");
endmodule // pwm_channel

// *** core/pwm_parallel_ctrl.sv ***
`timescale 1ns/10ps
// How it works
// RULE1: each channel has its own PWM; config D6 picks internal (1) or external clock.
// RULE2: channel-on low forces off; code n gives (n+1)/256 on; all ones fully on.
// RULE3: switching rate is clock/256 internal, clock/256 or /512 external.
// RULE4: config D7 doubles the external division to 512 per channel.
// RULE5: 3-bit delay field delays PWM start by code times 32 clock periods.
// RULE6: host writes duty and delay before setting the run bit.
// RULE7: both run bits set together on external clock start channels in lockstep.
// RULE8: external clock out of band with PWM running sets clock-fail and fault pin.
// RULE9: during clock failure the output follows the channel-on bit.
// RULE10: clock resumes and fault pin releases after flag read with clock in band.
// RULE11: after calibration word, chip-select low time sets the internal period.
// RULE12: low pulse outside window is discarded; previous or default period kept.
// RULE13: in parallel mode channel 1 switching settings come from channel 0.
// RULE14: parallel readback mirrors channel 0; open-load and short-to-battery flags stay separate.
// RULE15: parallel mode uses only channel 0 current-sense ratio bit.
// RULE16: parallel overcurrent on either channel kills both, flags set in both.
// RULE17: parallel severe short or overtemperature kills both, flags set in both.
// RULE18: parallel retry counter of channel 0 governs both and is mirrored.
// RULE19: overtemperature turns channel off, sets flag, pulls fault pin low.
// RULE20: overtemperature keeps fault pin low until both cool and a channel turns on.
// RULE21: auto-retry turns an overtemperature-off channel back on when it clears.
// RULE22: overtemperature flag clears on fault read only if cool and pin high.
// RULE23: channel-on bit is D8 of the duty register above the duty code.
// RULE24: PWM uses a free-running 8-bit counter compared against the duty code.
// RULE25: clock-bad and overtemperature indications are synchronous single-bit inputs.
module pwm_parallel_ctrl
	import pwm_ctrl_pkg::*;
#(
	parameter int CSB_MAX_CYCLES = CSB_MAX_CYC
)
(
	input wire logic i_ref_clk,
	input wire logic i_rst_n,
	input wire logic [8:0] i_duty_reg_ch0,
	input wire logic [8:0] i_duty_reg_ch1,
	input wire logic [8:0] i_chan_conf_reg_ch0,
	input wire logic [8:0] i_chan_conf_reg_ch1,
	input wire logic [7:0] i_ovc_conf_reg_ch0,
	input wire logic [7:0] i_ovc_conf_reg_ch1,
	input wire logic [8:0] i_global_conf_reg,
	input wire logic [1:0] i_retry_en,
	input wire logic [1:0] i_delatch,
	input wire logic i_ext_clk,
	input wire logic [1:0] i_ext_clk_bad,
	input wire logic [1:0] i_overtemp,
	input wire logic [1:0] i_overcurrent_det,
	input wire logic [1:0] i_severe_short_det,
	input wire logic [1:0] i_openload_on_det,
	input wire logic [1:0] i_openload_off_det,
	input wire logic [1:0] i_out_short_batt_det,
	input wire logic [1:0] i_fault_read,
	input wire logic [1:0] i_diag_read,
	input wire logic i_calib_write,
	input wire logic i_chip_select_n,
	output logic [1:0] o_switch_out_pin,
	output logic o_fault_pin_n,
	output logic [5:0] o_fault_flags_reg_ch0,
	output logic [5:0] o_fault_flags_reg_ch1,
	output logic [3:0] o_retry_reg_ch0,
	output logic [3:0] o_retry_reg_ch1,
	output logic [1:0] o_clock_fail,
	output logic [1:0] o_sense_ratio,
	output logic [9:0] o_int_period
);
	logic parallel;
	logic [8:0] duty_eff [NCH];
	logic [8:0] conf_eff [NCH];
	logic [7:0] ovc_eff [NCH];
	logic [1:0] run;
	logic [1:0] clk_int;
	logic [1:0] monitor;
	logic [1:0] tick;
	logic [1:0] on_bit;

	assign parallel = i_global_conf_reg[GCR_PARALLEL_BIT];
	assign run = {i_global_conf_reg[GCR_RUN1_BIT], i_global_conf_reg[GCR_RUN0_BIT]}; // [RULE6]
	// in parallel mode channel 1 switching settings follow channel 0; its diagnostic bits stay its own
	assign duty_eff[0] = i_duty_reg_ch0;
	assign conf_eff[0] = i_chan_conf_reg_ch0;
	assign ovc_eff[0] = i_ovc_conf_reg_ch0;
	assign duty_eff[1] = parallel ? i_duty_reg_ch0 : i_duty_reg_ch1; // [RULE13]
	assign conf_eff[1] = parallel ? {i_chan_conf_reg_ch1[8:6], i_chan_conf_reg_ch0[5:0]}
		: i_chan_conf_reg_ch1; // [RULE13]
	assign ovc_eff[1] = parallel ? i_ovc_conf_reg_ch0 : i_ovc_conf_reg_ch1; // [RULE15]

	// internal clock tick and chip-select calibration
	cal_state_e cal_r, cal_nxt;
	logic [MEAS_W-1:0] meas_r, meas_nxt;
	logic [PER_W-1:0] per_r, per_nxt;
	logic [PER_W-1:0] icnt_r, icnt_nxt;
	logic csn_prev_r, ext_prev_r;
	logic int_tick, ext_rise;
	logic [MEAS_W-1:0] min_cyc, max_cyc;

	assign min_cyc = MEAS_W'(CSB_MIN_CYC);
	assign max_cyc = MEAS_W'(CSB_MAX_CYCLES);
	assign int_tick = (icnt_r == per_r - 10'h001);
	assign ext_rise = i_ext_clk && !ext_prev_r;

	always_comb
	begin
		cal_nxt = cal_r;
		meas_nxt = meas_r;
		per_nxt = per_r;
		icnt_nxt = int_tick ? 10'h000 : icnt_r + 10'h001;
		case (cal_r)
			CAL_IDLE:
				if (i_calib_write)
					cal_nxt = CAL_WAIT_FALL; // [RULE11]
			CAL_WAIT_FALL:
				if (csn_prev_r && !i_chip_select_n)
				begin
					cal_nxt = CAL_MEASURE;
					meas_nxt = '0;
				end
			CAL_MEASURE:
				if (!i_chip_select_n)
				begin
					if (meas_r <= max_cyc)
						meas_nxt = meas_r + 18'h00001;
				end
				else
				begin
					cal_nxt = CAL_IDLE;
					// low pulse sets 256 internal periods; out-of-window pulses are dropped
					if (meas_r >= min_cyc && meas_r <= max_cyc)
						per_nxt = meas_r[PER_SHIFT +: PER_W]; // [RULE11] [RULE12]
				end
			default:
				cal_nxt = CAL_IDLE;
		endcase
	end

	always_ff @(posedge i_ref_clk)
	begin
		if (!i_rst_n)
		begin
			cal_r <= CAL_IDLE;
			meas_r <= '0;
			per_r <= INT_PER_DEFAULT; // [RULE12]
			icnt_r <= 10'h000;
			csn_prev_r <= 1'b1;
			ext_prev_r <= 1'b0;
			o_int_period <= INT_PER_DEFAULT;
		end
		else
		begin
			cal_r <= cal_nxt;
			meas_r <= meas_nxt;
			per_r <= per_nxt;
			icnt_r <= icnt_nxt;
			csn_prev_r <= i_chip_select_n;
			ext_prev_r <= i_ext_clk;
			o_int_period <= per_nxt;
		end
	end

	// per-channel clock, faults and retry
	logic [1:0] cf_r, cf_nxt;
	logic [FLT_W-1:0] flt_r [NCH];
	logic [FLT_W-1:0] flt_nxt [NCH];
	logic [RETRY_W-1:0] rty_r [NCH];
	logic [RETRY_W-1:0] rty_nxt [NCH];
	logic [1:0] kill_r, kill_nxt;
	logic [1:0] on_prev_r;
	logic [1:0] retry_on;
	logic [1:0] turn_on;
	logic [1:0] oc_ev, sc_ev, ot_ev;
	logic ot_pin_r, ot_pin_nxt;
	logic fault_pin_nxt;

	genvar g;
	generate
		for (g = 0; g < NCH; g++)
		begin : g_ch
			logic cause;
			logic rty_en;
			assign on_bit[g] = duty_eff[g][DUTY_ON_BIT]; // [RULE23]
			assign clk_int[g] = ovc_eff[g][OVC_CLK_INT_BIT]; // [RULE1]
			assign monitor[g] = !clk_int[g] && run[g];
			// a failed external clock is ignored entirely
			assign tick[g] = clk_int[g] ? int_tick : (ext_rise && !cf_r[g]); // [RULE1] [RULE8]
			assign oc_ev[g] = parallel ? |i_overcurrent_det : i_overcurrent_det[g]; // [RULE16]
			assign sc_ev[g] = parallel ? |i_severe_short_det : i_severe_short_det[g]; // [RULE17]
			assign ot_ev[g] = parallel ? |i_overtemp : i_overtemp[g]; // [RULE17] [RULE25]
			assign cause = oc_ev[g] || sc_ev[g] || ot_ev[g];
			assign rty_en = parallel ? i_retry_en[0] : i_retry_en[g];
			assign retry_on[g] = kill_r[g] && !cause && rty_en && rty_r[g] != RETRY_MAX; // [RULE21]
			assign turn_on[g] = (on_bit[g] && !on_prev_r[g]) || retry_on[g];

			always_comb
			begin
				logic [FLT_W-1:0] f;
				logic [RETRY_W-1:0] r;
				logic k;
				f = flt_r[g];
				r = rty_r[g];
				k = kill_r[g];
				cf_nxt[g] = cf_r[g];
				// clear first so a same-cycle event wins
				if (i_diag_read[g] && !i_ext_clk_bad[g])
					cf_nxt[g] = 1'b0; // [RULE10]
				if (monitor[g] && i_ext_clk_bad[g])
					cf_nxt[g] = 1'b1; // [RULE8] [RULE25]
				if (i_fault_read[g])
				begin
					if (!oc_ev[g] && !k)
						f[FLT_OC] = 1'b0;
					if (!sc_ev[g] && !k)
						f[FLT_SC] = 1'b0;
					if (!i_overtemp[g] && o_fault_pin_n)
						f[FLT_OT] = 1'b0; // [RULE22]
					if (!i_openload_on_det[g])
						f[FLT_OLON] = 1'b0;
					if (!i_openload_off_det[g])
						f[FLT_OLOFF] = 1'b0;
					if (!i_out_short_batt_det[g])
						f[FLT_OS] = 1'b0;
				end
				f[FLT_OC] = f[FLT_OC] | oc_ev[g]; // [RULE16]
				f[FLT_SC] = f[FLT_SC] | sc_ev[g]; // [RULE17]
				f[FLT_OT] = f[FLT_OT] | ot_ev[g]; // [RULE19]
				f[FLT_OLON] = f[FLT_OLON] | i_openload_on_det[g]; // [RULE14]
				f[FLT_OLOFF] = f[FLT_OLOFF] | i_openload_off_det[g]; // [RULE14]
				f[FLT_OS] = f[FLT_OS] | i_out_short_batt_det[g]; // [RULE14]
				if (retry_on[g])
				begin
					k = 1'b0; // [RULE21]
					r = r + 4'h1;
				end
				if (i_delatch[g] && !cause)
				begin
					k = 1'b0;
					r = 4'h0;
				end
				if (cause)
					k = 1'b1; // [RULE19]
				flt_nxt[g] = f;
				if (g == 1 && parallel)
				begin
					r = rty_nxt[0]; // [RULE18]
					k = kill_nxt[0]; // [RULE18]
				end
				rty_nxt[g] = r;
				kill_nxt[g] = k;
			end

			pwm_channel u_pwm (
				.i_ref_clk(i_ref_clk),
				.i_rst_n(i_rst_n),
				.i_tick(tick[g]),
				.i_div2(!clk_int[g] && ovc_eff[g][OVC_DIV2_BIT]),
				.i_run(run[g]),
				.i_on(on_bit[g]),
				.i_duty(duty_eff[g][DUTY_W-1:0]),
				.i_delay(conf_eff[g][CONF_DLY_LSB +: DLY_W]),
				.i_force(cf_r[g]),
				.i_kill(kill_r[g]),
				.o_out(o_switch_out_pin[g])
			);
		end
	endgenerate

	always_comb
	begin
		ot_pin_nxt = ot_pin_r;
		if (!(|i_overtemp) && |turn_on)
			ot_pin_nxt = 1'b0; // [RULE20]
		if (|i_overtemp)
			ot_pin_nxt = 1'b1; // [RULE19]
		fault_pin_nxt = !(ot_pin_nxt || |cf_nxt || |kill_nxt); // [RULE8]
	end

	always_ff @(posedge i_ref_clk)
	begin
		if (!i_rst_n)
		begin
			cf_r <= 2'b00;
			kill_r <= 2'b00;
			on_prev_r <= 2'b00;
			ot_pin_r <= 1'b0;
			flt_r[0] <= '0;
			flt_r[1] <= '0;
			rty_r[0] <= '0;
			rty_r[1] <= '0;
			o_fault_pin_n <= 1'b1;
			o_fault_flags_reg_ch0 <= '0;
			o_fault_flags_reg_ch1 <= '0;
			o_retry_reg_ch0 <= '0;
			o_retry_reg_ch1 <= '0;
			o_clock_fail <= 2'b00;
			o_sense_ratio <= 2'b00;
		end
		else
		begin
			cf_r <= cf_nxt;
			kill_r <= kill_nxt;
			on_prev_r <= on_bit;
			ot_pin_r <= ot_pin_nxt;
			flt_r[0] <= flt_nxt[0];
			flt_r[1] <= flt_nxt[1];
			rty_r[0] <= rty_nxt[0];
			rty_r[1] <= rty_nxt[1];
			o_fault_pin_n <= fault_pin_nxt;
			o_fault_flags_reg_ch0 <= flt_nxt[0];
			o_fault_flags_reg_ch1 <= flt_nxt[1]; // [RULE14]
			o_retry_reg_ch0 <= rty_nxt[0];
			o_retry_reg_ch1 <= rty_nxt[1]; // [RULE18]
			o_clock_fail <= cf_nxt;
			o_sense_ratio <= {ovc_eff[1][OVC_SENSE_BIT], ovc_eff[0][OVC_SENSE_BIT]}; // [RULE15]
		end
	end

	a_clk_fail_flag: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // [RULE8]
		(monitor[0] && i_ext_clk_bad[0]) |=> (o_clock_fail[0] && !o_fault_pin_n))
		else $error("clock failure not flagged");
	a_clk_fail_hold: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // [RULE10]
		(o_clock_fail[0] && !i_diag_read[0]) |=> o_clock_fail[0]) else $error("clock fail dropped early");
	a_par_oc_both: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // [RULE16]
		(parallel && i_overcurrent_det[1]) |=> (o_fault_flags_reg_ch0[FLT_OC]
		&& o_fault_flags_reg_ch1[FLT_OC])) else $error("parallel overcurrent not in both");
	a_ot_pin_low: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // [RULE19]
		ot_ev[0] |=> (!o_fault_pin_n && o_fault_flags_reg_ch0[FLT_OT] && kill_r[0]))
		else $error("overtemperature not handled");
	a_retry_mirror: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // [RULE18]
		parallel |=> (o_retry_reg_ch1 == o_retry_reg_ch0)) else $error("retry not mirrored");
	a_ot_flag_clear: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // [RULE22]
		$fell(o_fault_flags_reg_ch0[FLT_OT]) |-> ($past(i_fault_read[0]) && $past(o_fault_pin_n)))
		else $error("overtemperature flag cleared without read");
	a_cal_period: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // [RULE12]
		(per_r != $past(per_r)) |-> ($past(cal_r) == CAL_MEASURE && $past(meas_r) >= min_cyc))
		else $error("period changed outside valid calibration");
endmodule // pwm_parallel_ctrl

// *** pkg/pwm_ctrl_pkg.sv ***
package pwm_ctrl_pkg;
	localparam int NCH = 2;
	// duty register fields
	localparam int DUTY_W = 8;
	localparam int DUTY_ON_BIT = 8;
	localparam logic [7:0] DUTY_FULL = 8'hFF;
	// channel configuration fields
	localparam int CONF_DLY_LSB = 0;
	localparam int DLY_W = 3;
	localparam int DLY_UNIT_W = 5;
	// overcurrent configuration fields
	localparam int OVC_SENSE_BIT = 5;
	localparam int OVC_CLK_INT_BIT = 6;
	localparam int OVC_DIV2_BIT = 7;
	// global configuration fields
	localparam int GCR_RUN0_BIT = 7;
	localparam int GCR_RUN1_BIT = 8;
	localparam int GCR_PARALLEL_BIT = 4;
	// fault register bit positions
	localparam int FLT_W = 6;
	localparam int FLT_OC = 0;
	localparam int FLT_SC = 1;
	localparam int FLT_OT = 2;
	localparam int FLT_OLON = 3;
	localparam int FLT_OLOFF = 4;
	localparam int FLT_OS = 5;
	localparam int RETRY_W = 4;
	localparam logic [3:0] RETRY_MAX = 4'hF;
	// calibration timing
	localparam int CLK_PERIOD_NS = 8;
	localparam int CSB_MIN_NS = 20000;
	localparam int CSB_MAX_NS = 2000000;
	localparam int CSB_MIN_CYC = (CSB_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CSB_MAX_CYC = CSB_MAX_NS / CLK_PERIOD_NS;
	localparam int MEAS_W = 18;
	localparam int PER_W = 10;
	localparam int PER_SHIFT = 8;
	localparam logic [9:0] INT_PER_DEFAULT = 10'h3E8;
	typedef enum logic [1:0] {
		CAL_IDLE = 2'b00,
		CAL_WAIT_FALL = 2'b01,
		CAL_MEASURE = 2'b10
	} cal_state_e;
endpackage

// *** tb/dual_channel_pwm_parallel_ctrl_test.sv ***
`timescale 1ns/10ps
module dual_channel_pwm_parallel_ctrl_test;
	import pwm_ctrl_pkg::*;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic [8:0] duty0 = '0, duty1 = '0, conf0 = '0, conf1 = '0, global_conf_reg = '0;
	logic [7:0] ovc0 = '0, ovc1 = '0;
	logic [1:0] rty = '0, dlt = '0, bad = '0, ot = '0, oc = '0, sc = '0;
	logic [1:0] olon = '0, oloff = '0, osb = '0, frd = '0, drd = '0;
	logic cal = 1'b0, ext_run = 1'b0, ext_clk, csn, fault_n;
	logic [1:0] out, clk_fail, sense;
	logic [5:0] flt0, flt1;
	logic [9:0] per;
	logic [3:0] rty0, rty1;
	int fail_count = 0, compares = 0, highs, rises;
	logic [8:0] tbl [4] = '{9'h000, 9'h100, 9'h13F, 9'h1FF};
	int cal_len [3] = '{2600, 100, 4100};
	always #4 clk = ~clk;
	host_model host (.i_ref_clk(clk), .i_clk_run(ext_run), .o_ext_clk(ext_clk),
		.o_chip_select_n(csn));
	// short calibration ceiling keeps the over-length case cheap
	pwm_parallel_ctrl #(.CSB_MAX_CYCLES(4000)) dut (.i_ref_clk(clk), .i_rst_n(rst_n),
		.i_duty_reg_ch0(duty0), .i_duty_reg_ch1(duty1), .i_chan_conf_reg_ch0(conf0),
		.i_chan_conf_reg_ch1(conf1), .i_ovc_conf_reg_ch0(ovc0), .i_ovc_conf_reg_ch1(ovc1),
		.i_global_conf_reg(global_conf_reg), .i_retry_en(rty), .i_delatch(dlt), .i_ext_clk(ext_clk),
		.i_ext_clk_bad(bad), .i_overtemp(ot), .i_overcurrent_det(oc),
		.i_severe_short_det(sc), .i_openload_on_det(olon), .i_openload_off_det(oloff),
		.i_out_short_batt_det(osb), .i_fault_read(frd), .i_diag_read(drd),
		.i_calib_write(cal), .i_chip_select_n(csn), .o_switch_out_pin(out),
		.o_fault_pin_n(fault_n), .o_fault_flags_reg_ch0(flt0), .o_fault_flags_reg_ch1(flt1),
		.o_retry_reg_ch0(rty0), .o_retry_reg_ch1(rty1), .o_clock_fail(clk_fail),
		.o_sense_ratio(sense), .o_int_period(per));
	task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
		compares++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("[ERR] %0t %s: seen %0h expected %0h", $time, msg, seen, exp);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(negedge clk);
	endtask
	task automatic pulse(ref logic [1:0] s, input int b);
		s[b] = 1'b1;
		cyc(1);
		s[b] = 1'b0;
	endtask
	task automatic restart;
		cyc(1);
		{duty0, duty1, conf0, conf1, global_conf_reg, ovc0, ovc1} = '0;
		{rty, dlt, bad, ot, oc, sc, olon, oloff, osb, frd, drd, cal, ext_run} = '0;
		rst_n = 1'b0;
		cyc(6);
		rst_n = 1'b1;
	endtask
	task automatic count_high(input int n, input int ch);
		logic prev;
		highs = 0;
		rises = 0;
		prev = out[ch];
		repeat (n)
		begin
			@(negedge clk);
			if (out[ch] === 1'b1)
				highs++;
			if (out[ch] === 1'b1 && prev !== 1'b1)
				rises++;
			prev = out[ch];
		end
	endtask
	task automatic close_out;
		$display("compares %0d mismatches %0d", compares, fail_count);
		if (fail_count == 0 && compares > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	initial
	begin
		#400000;
		fail_count++;
		close_out();
	end
	initial
	begin
		restart();
		cyc(1);
		check(out, 0, "reset outputs");
		check(fault_n, 1, "reset fault pin");
		check(per, 10'h3E8, "reset period");
		$display("test reset done");
		foreach (tbl[i])
		begin
			restart();
			ext_run = 1'b1;
			duty0 = tbl[i];
			cyc(2);
			global_conf_reg[GCR_RUN0_BIT] = 1'b1;
			cyc(300);
			count_high(1024, 0);
			check(highs, tbl[i][8] ? (tbl[i][7:0] + 1) * 4 : 0, "duty high time");
		end
		$display("test duty codes done");
		restart();
		ext_run = 1'b1;
		{duty0, duty1} = {9'h17F, 9'h17F};
		cyc(2);
		global_conf_reg[GCR_RUN1_BIT:GCR_RUN0_BIT] = 2'b11;
		cyc(5);
		highs = 0;
		repeat (1024)
		begin
			@(negedge clk);
			if (out[0] !== out[1])
				highs++;
		end
		check(highs, 0, "lockstep");
		ovc1[OVC_DIV2_BIT] = 1'b1;
		cyc(1200);
		count_high(2048, 1);
		check(rises, 1, "doubled division periods");
		check(highs, 128 * 8, "doubled division high time");
		count_high(2048, 0);
		check(rises, 2, "plain division periods");
		$display("test lockstep and division done");
		restart();
		ext_run = 1'b1;
		duty0 = 9'h1FF;
		conf0[2:0] = 3'd1;
		cyc(2);
		global_conf_reg[GCR_RUN0_BIT] = 1'b1;
		count_high(120, 0);
		check(highs, 0, "delayed start low");
		count_high(20, 0);
		check(highs > 0, 1, "delayed start high");
		$display("test delay done");
		restart();
		ext_run = 1'b1;
		duty0 = 9'h100;
		cyc(2);
		global_conf_reg[GCR_RUN0_BIT] = 1'b1;
		cyc(20);
		bad[0] = 1'b1;
		cyc(3);
		check(clk_fail[0], 1, "clock fail flag");
		check(fault_n, 0, "clock fail pin");
		count_high(600, 0);
		check(highs, 600, "fail follows on bit");
		duty0[DUTY_ON_BIT] = 1'b0;
		cyc(3);
		check(out[0], 0, "fail follows off bit");
		pulse(drd, 0);
		cyc(2);
		check(clk_fail[0], 1, "flag kept while bad");
		bad[0] = 1'b0;
		pulse(drd, 0);
		cyc(2);
		check(clk_fail[0], 0, "flag cleared");
		check(fault_n, 1, "pin released");
		$display("test clock fail done");
		restart();
		foreach (cal_len[i])
		begin
			cal = 1'b1;
			cyc(1);
			cal = 1'b0;
			host.cs_pulse(cal_len[i]);
			cyc(3);
			check(per, cal_len[0] >> PER_SHIFT, "calibrated period");
		end
		ovc0[OVC_CLK_INT_BIT] = 1'b1;
		duty0 = 9'h13F;
		cyc(2);
		global_conf_reg[GCR_RUN0_BIT] = 1'b1;
		cyc(100);
		count_high(256 * (cal_len[0] >> PER_SHIFT), 0);
		check(highs, 64 * (cal_len[0] >> PER_SHIFT), "internal clock duty");
		$display("test calibration done");
		for (int k = 0; k < 3; k++)
		begin
			restart();
			global_conf_reg[GCR_PARALLEL_BIT] = 1'b1;
			duty0 = 9'h1FF;
			ovc0[OVC_SENSE_BIT] = 1'b1;
			rty = 2'b11;
			cyc(3);
			check(out, 2'b11, "parallel both on");
			check(sense, 2'b11, "sense ratio mirror");
			olon[1] = 1'b1;
			oc[1] = (k == 0);
			sc[1] = (k == 1);
			ot[1] = (k == 2);
			cyc(3);
			check(out, 2'b00, "parallel both off");
			check({flt1[k], flt0[k]}, 2'b11, "fault flag both");
			check({flt1[FLT_OLON], flt0[FLT_OLON]}, 2'b10, "open load apart");
			check(fault_n, 0, "fault pin low");
		end
		pulse(frd, 0);
		cyc(2);
		check(flt0[FLT_OT], 1, "hot flag kept");
		{ot, olon} = '0;
		highs = 0;
		while (out[0] !== 1'b1 && highs < 20000)
		begin
			cyc(1);
			highs++;
		end
		check(out[0], 1, "auto retry on");
		cyc(3);
		check(fault_n, 1, "pin high after cool");
		check({rty1, rty0}, 8'h11, "retry count mirrored");
		pulse(frd, 0);
		cyc(2);
		check(flt0[FLT_OT], 0, "hot flag cleared");
		pulse(dlt, 0);
		cyc(2);
		check({rty1, rty0}, 8'h00, "delatch releases both");
		$display("test parallel faults done");
		close_out();
	end
endmodule // dual_channel_pwm_parallel_ctrl_test

// *** tb/host_model.sv ***
`timescale 1ns/10ps
module host_model
(
	input wire logic i_ref_clk,
	input wire logic i_clk_run,
	output logic o_ext_clk,
	output logic o_chip_select_n
);
	logic [1:0] div_r;
	initial
	begin
		div_r = 2'b00;
		o_ext_clk = 1'b0;
		o_chip_select_n = 1'b1;
	end
	// one external tick per 4 reference cycles; held low when stopped
	always @(negedge i_ref_clk)
	begin
		if (i_clk_run)
			div_r <= div_r + 2'b01;
		o_ext_clk <= i_clk_run & div_r[1];
	end
	task automatic cs_pulse(input int cycles);
		@(negedge i_ref_clk);
		o_chip_select_n = 1'b0;
		repeat (cycles) @(negedge i_ref_clk);
		o_chip_select_n = 1'b1;
	endtask
endmodule // host_model
